// *** rtl/crbc_pkg.sv ***
// Package: offsets, field positions, reset values and states of the ratio/boost bank
package crbc_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_FAULT   = 8'h12;  // Only the recovery kick bit is decoded here
   localparam logic [7:0] ADDR_RATIO   = 8'h14;  // clock_ratio_setting
   localparam logic [7:0] ADDR_BOOST1  = 8'h15;  // boost_control_one
   localparam logic [7:0] ADDR_BOOST2  = 8'h16;  // boost_control_two
   localparam logic [7:0] ADDR_SOFTRST = 8'hff;  // software_restart_trigger

   // ---------------------------------------------------------------
   // Reset values and trigger value
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_RATIO    = 8'h11;  // Auto select on, code 128 x fs
   localparam logic [7:0] RST_BOOST1   = 8'h03;  // Pulse skip allowed, 1.25 MHz
   localparam logic [7:0] RST_BOOST2   = 8'h00;  // Auto recovery, lowest gm
   localparam logic [7:0] SOFTRST_KEY  = 8'h00;  // Value that starts a soft reset
   localparam logic [7:0] READ_NONE    = 8'h00;  // Unmapped and write-only reads

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int AUTO_BIT   = 4;  // auto_ratio_select
   localparam int CODE_MSB   = 3;  // ratio_code [3:0]
   localparam int SPEED_MSB  = 7;  // pullup_driver_speed [7:6]
   localparam int SPEED_LSB  = 6;
   localparam int DISCH_BIT  = 2;  // discharge_switch_on
   localparam int PWM_BIT    = 1;  // forced_pwm_n
   localparam int FREQ_BIT   = 0;  // converter_freq_pick
   localparam int RECOV_BIT  = 3;  // booster_recovery_mode
   localparam int GM_MSB     = 1;  // error_amp_gain_pick [1:0]
   localparam int KICK_BIT   = 3;  // manual_recovery_kick

   // ---------------------------------------------------------------
   // Ratio detection table: clocks per frame for each code
   // ---------------------------------------------------------------
   localparam int         RATIO_CODES = 10;
   localparam int         CNT_W       = 10;
   localparam logic [9:0] CNT_MAX     = 10'h3ff;
   localparam logic [9:0] RATIO_MULT [RATIO_CODES] = '{
      10'h040, 10'h080, 10'h0c0, 10'h100, 10'h180,
      10'h200, 10'h032, 10'h064, 10'h0c8, 10'h190};

   // ---------------------------------------------------------------
   // Control port states
   // ---------------------------------------------------------------
   localparam logic [3:0] BYTE_BITS = 4'h8;  // Bits per byte on the port
   localparam logic [3:0] LAST_TX   = 4'h7;  // Index of the last sent bit
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
      ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
   } crbc_state_e;

endpackage : crbc_pkg

// *** rtl/crbc_link_if.sv ***
// Interface: line events and ratio detection results handed to the register core
interface crbc_link_if;
   logic       scl_rise;  // Clock line rose this cycle
   logic       scl_fall;  // Clock line fell this cycle
   logic       start;     // Start or repeated start seen
   logic       stop;      // Stop seen
   logic       sda;       // Current data line level
   logic       det_valid; // One-cycle pulse: a ratio was recognised
   logic [3:0] det_code;  // Recognised ratio code

   modport edge_src (output scl_rise, scl_fall, start, stop, sda);
   modport det      (output det_valid, det_code);
   modport core     (input scl_rise, scl_fall, start, stop, sda, det_valid, det_code);
endinterface : crbc_link_if

// *** rtl/crbc_line_edges.sv ***
// Edge and start/stop detection on the control port lines
module crbc_line_edges
   import crbc_pkg::*;
(
   // Clock and reset
   input  wire logic     i_ref_clk,
   input  wire logic     i_reset,
   // Port lines
   input  wire logic     i_scl,
   input  wire logic     i_sda,
   // Events out
   crbc_link_if.edge_src link
);

   logic scl_d_r;  // Clock line one cycle ago
   logic sda_d_r;  // Data line one cycle ago

   // ---------------------------------------------------------------
   // Line history; idle bus level is high
   // ---------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= i_scl;
         sda_d_r <= i_sda;
      end
   end

   // Data moving while clock is high marks start or stop
   assign link.scl_rise = i_scl & ~scl_d_r;
   assign link.scl_fall = ~i_scl & scl_d_r;
   assign link.start    = i_scl & scl_d_r & sda_d_r & ~i_sda;
   assign link.stop     = i_scl & scl_d_r & ~sda_d_r & i_sda;
   assign link.sda      = i_sda;

endmodule : crbc_line_edges

// *** rtl/crbc_ratio_det.sv ***
// Master clock to frame rate ratio detector
module crbc_ratio_det
   import crbc_pkg::*;
(
   // Clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_reset,
   // Frame sync, synchronous to the master clock
   input  wire logic i_frame_sync,
   // Result out
   crbc_link_if.det  link
);

   logic                   sync_d_r;  // Frame sync one cycle ago
   logic [CNT_W-1:0]       cnt_r;     // Clocks since the last frame edge
   logic                   seen_r;    // A first edge has been counted from
   logic [RATIO_CODES-1:0] hit;       // Period matches a table entry
   logic [3:0]             code_w;    // Encoded matching entry
   logic                   edge_w;    // Frame sync rising edge

   assign edge_w = i_frame_sync & ~sync_d_r;

   // ---------------------------------------------------------------
   // Compare the measured period with every table entry
   // ---------------------------------------------------------------
   for (genvar g = 0; g < RATIO_CODES; g++) begin : g_match
      assign hit[g] = (cnt_r == RATIO_MULT[g]);
   end

   // Entries are distinct, so at most one hit is set
   always_comb begin
      code_w = 4'h0;
      for (int i = 0; i < RATIO_CODES; i++) begin
         if (hit[i]) begin
            code_w = 4'(i);
         end
      end
   end

   // Period counter; saturates so a stopped frame sync never matches
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         sync_d_r <= 1'b0;
         cnt_r    <= '0;
         seen_r   <= 1'b0;
      end else begin
         sync_d_r <= i_frame_sync;
         if (edge_w) begin
            cnt_r  <= 10'h001;
            seen_r <= 1'b1;
         end else if (cnt_r != CNT_MAX) begin
            cnt_r <= cnt_r + 10'h001;
         end
      end
   end

   // Report only periods that match a known ratio exactly
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         link.det_valid <= 1'b0;
         link.det_code  <= 4'h0;
      end else begin
         link.det_valid <= edge_w & seen_r & (|hit);
         link.det_code  <= code_w;
      end
   end

endmodule : crbc_ratio_det

// *** rtl/crbc_regs.sv ***
// Clock ratio and boost control register bank behind the two-wire control port
//
// Function
// RL1 - Bit 4 picks auto (1) or manual ratio; resets 1
// RL2 - Auto mode writes detected ratio into ratio_code
// RL3 - Manual mode uses ratio_code; codes 0-5 are 64..512fs
// RL4 - Codes 6-9 are 50..400fs; field resets to 0001
// RL5 - Boost1 bits 7:6 driver speed, reset 00
// RL6 - Boost1 bit 2 discharge switch, reset off
// RL7 - Boost1 bit 1: 0 forced PWM, reset 1
// RL8 - Boost1 bit 0 switching clock pick, reset 1
// RL9 - Boost2 bit 3 fault recovery mode, reset auto
// RL10 - Boost2 bits 1:0 error amplifier gain pick
// RL11 - Writing 0x00 to 0xFF starts soft reset
// RL12 - Reserved bits reset zero and stay writable
// RL13 - Kick write in manual mode makes one recovery
// RL14 - Soft reset restores registers, port keeps working
module crbc_regs
   import crbc_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h34  // Port address of this device
)(
   // Clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_reset,
   // Control port
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output logic            o_sda_o,
   output logic            o_sda_oe,
   // Frame sync for ratio detection
   input  wire logic       i_frame_sync,
   // Ratio settings
   output logic            o_auto_ratio_select,
   output logic [3:0]      o_ratio_code,
   // Boost settings
   output logic [1:0]      o_pullup_driver_speed,
   output logic            o_discharge_switch_on,
   output logic            o_forced_pwm_n,
   output logic            o_converter_freq_pick,
   output logic            o_booster_recovery_mode,
   output logic [1:0]      o_error_amp_gain_pick,
   // Event pulses
   output logic            o_soft_reset,
   output logic            o_recovery_attempt
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   crbc_link_if link ();              // Events from the two helpers

   crbc_state_e state_r;              // Control port state
   logic [3:0]  bit_cnt_r;            // Bits taken or sent in this byte
   logic [7:0]  shift_r;              // Received byte
   logic [7:0]  tx_r;                 // Byte being sent
   logic [7:0]  ptr_r;                // Register pointer
   logic        rw_r;                 // Current transfer is a read
   logic        nack_r;               // Host refused the last read byte
   logic        sda_oe_r;             // Pulling the data line low
   logic        wr_stb_r;             // One-cycle write to a register
   logic [7:0]  wr_addr_r;            // Address of that write
   logic [7:0]  wr_data_r;            // Data of that write
   logic [7:0]  ratio_r;              // clock_ratio_setting
   logic [7:0]  boost1_r;             // boost_control_one
   logic [7:0]  boost2_r;             // boost_control_two
   logic        soft_rst_r;           // Soft reset pulse
   logic        recov_r;              // Recovery attempt pulse
   logic        soft_hit;             // Soft reset key written now
   logic        kick_hit;             // Recovery kick accepted now
   logic [7:0]  rd_data;              // Register at the pointer

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   crbc_line_edges u_edges (
      .i_ref_clk (i_ref_clk),
      .i_reset   (i_reset),
      .i_scl     (i_scl),
      .i_sda     (i_sda),
      .link      (link)
   );

   crbc_ratio_det u_det (
      .i_ref_clk    (i_ref_clk),
      .i_reset      (i_reset),
      .i_frame_sync (i_frame_sync),
      .link         (link)
   );

   // ---------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------
   // Trigger register reads back zero; unmapped offsets read zero too
   always_comb begin
      case (ptr_r)
         ADDR_RATIO:  rd_data = ratio_r;
         ADDR_BOOST1: rd_data = boost1_r;
         ADDR_BOOST2: rd_data = boost2_r;
         default:     rd_data = READ_NONE;
      endcase
   end

   // ---------------------------------------------------------------
   // Control port byte engine
   // ---------------------------------------------------------------
   // Only the line events advance this; soft reset leaves it alone so
   // the transfer that carried the key still finishes cleanly
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         state_r   <= ST_IDLE;
         bit_cnt_r <= 4'h0;
         shift_r   <= 8'h00;
         tx_r      <= 8'h00;
         ptr_r     <= 8'h00;
         rw_r      <= 1'b0;
         nack_r    <= 1'b0;
         sda_oe_r  <= 1'b0;
         wr_stb_r  <= 1'b0;
         wr_addr_r <= 8'h00;
         wr_data_r <= 8'h00;
      end else begin
         wr_stb_r <= 1'b0;
         if (link.start) begin
            // Start or repeated start: expect an address byte
            state_r   <= ST_ADDR;
            bit_cnt_r <= 4'h0;
            sda_oe_r  <= 1'b0;
         end else if (link.stop) begin
            state_r  <= ST_IDLE;
            sda_oe_r <= 1'b0;
         end else if (link.scl_rise) begin
            case (state_r)
               ST_ADDR, ST_PTR, ST_WDATA: begin
                  shift_r   <= {shift_r[6:0], link.sda};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end
               ST_RDATA_ACK: begin
                  nack_r <= link.sda;
               end
               default: begin
               end
            endcase
         end else if (link.scl_fall) begin
            case (state_r)
               ST_ADDR: begin
                  if (bit_cnt_r == BYTE_BITS) begin
                     if (shift_r[7:1] == DEV_ADDR) begin
                        rw_r     <= shift_r[0];
                        sda_oe_r <= 1'b1;
                        state_r  <= ST_ADDR_ACK;
                     end else begin
                        state_r <= ST_IDLE;
                     end
                  end
               end
               ST_ADDR_ACK: begin
                  bit_cnt_r <= 4'h0;
                  if (rw_r) begin
                     // First read byte; pointer moves on past it
                     tx_r     <= rd_data;
                     sda_oe_r <= ~rd_data[7];
                     ptr_r    <= ptr_r + 8'h01;
                     state_r  <= ST_RDATA;
                  end else begin
                     sda_oe_r <= 1'b0;
                     state_r  <= ST_PTR;
                  end
               end
               ST_PTR: begin
                  if (bit_cnt_r == BYTE_BITS) begin
                     ptr_r    <= shift_r;
                     sda_oe_r <= 1'b1;
                     state_r  <= ST_PTR_ACK;
                  end
               end
               ST_PTR_ACK, ST_WDATA_ACK: begin
                  // Pointer steps after each data byte for burst writes
                  if (state_r == ST_WDATA_ACK) begin
                     ptr_r <= ptr_r + 8'h01;
                  end
                  sda_oe_r  <= 1'b0;
                  bit_cnt_r <= 4'h0;
                  state_r   <= ST_WDATA;
               end
               ST_WDATA: begin
                  if (bit_cnt_r == BYTE_BITS) begin
                     wr_stb_r  <= 1'b1;
                     wr_addr_r <= ptr_r;
                     wr_data_r <= shift_r;
                     sda_oe_r  <= 1'b1;
                     state_r   <= ST_WDATA_ACK;
                  end
               end
               ST_RDATA: begin
                  if (bit_cnt_r == LAST_TX) begin
                     sda_oe_r <= 1'b0;
                     state_r  <= ST_RDATA_ACK;
                  end else begin
                     tx_r      <= {tx_r[6:0], 1'b0};
                     sda_oe_r  <= ~tx_r[6];
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end
               end
               ST_RDATA_ACK: begin
                  bit_cnt_r <= 4'h0;
                  if (nack_r) begin
                     state_r <= ST_IDLE;
                  end else begin
                     tx_r     <= rd_data;
                     sda_oe_r <= ~rd_data[7];
                     ptr_r    <= ptr_r + 8'h01;
                     state_r  <= ST_RDATA;
                  end
               end
               default: begin
                  state_r <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Register writes and soft reset
   // ---------------------------------------------------------------
   // Any other value written to the trigger is ignored
   assign soft_hit = wr_stb_r && (wr_addr_r == ADDR_SOFTRST)
                     && (wr_data_r == SOFTRST_KEY);  // [RL11]
   // The kick has no storage; in auto recovery it is dropped
   assign kick_hit = wr_stb_r && (wr_addr_r == ADDR_FAULT)
                     && wr_data_r[KICK_BIT] && boost2_r[RECOV_BIT];  // [RL13]

   // Whole bytes are stored, so reserved bits stay writable storage
   always_ff @(posedge i_ref_clk) begin
      if (i_reset || soft_hit) begin  // [RL14]
         ratio_r  <= RST_RATIO;   // [RL1] [RL4] [RL12]
         boost1_r <= RST_BOOST1;  // [RL5] [RL6] [RL7] [RL8] [RL12]
         boost2_r <= RST_BOOST2;  // [RL9] [RL10] [RL12]
      end else begin
         if (wr_stb_r && (wr_addr_r == ADDR_RATIO)) begin
            ratio_r <= wr_data_r;  // [RL3] [RL12]
         end
         if (wr_stb_r && (wr_addr_r == ADDR_BOOST1)) begin
            boost1_r <= wr_data_r;  // [RL5] [RL6] [RL7] [RL8]
         end
         if (wr_stb_r && (wr_addr_r == ADDR_BOOST2)) begin
            boost2_r <= wr_data_r;  // [RL9] [RL10]
         end
         // Detection wins over a host write of the code in the same cycle
         if (ratio_r[AUTO_BIT] && link.det_valid) begin
            ratio_r[CODE_MSB:0] <= link.det_code;  // [RL2]
         end
      end
   end

   // Event pulses, one cycle each
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         soft_rst_r <= 1'b0;
         recov_r    <= 1'b0;
      end else begin
         soft_rst_r <= soft_hit;  // [RL11]
         recov_r    <= kick_hit;  // [RL13]
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Open-drain: the line is only ever pulled low
   assign o_sda_o                 = 1'b0;
   assign o_sda_oe                = sda_oe_r;
   assign o_auto_ratio_select     = ratio_r[AUTO_BIT];
   assign o_ratio_code            = ratio_r[CODE_MSB:0];
   assign o_pullup_driver_speed   = boost1_r[SPEED_MSB:SPEED_LSB];
   assign o_discharge_switch_on   = boost1_r[DISCH_BIT];
   assign o_forced_pwm_n          = boost1_r[PWM_BIT];
   assign o_converter_freq_pick   = boost1_r[FREQ_BIT];
   assign o_booster_recovery_mode = boost2_r[RECOV_BIT];
   assign o_error_amp_gain_pick   = boost2_r[GM_MSB:0];
   assign o_soft_reset            = soft_rst_r;
   assign o_recovery_attempt      = recov_r;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);

   sequence s_key_write;
      wr_stb_r && (wr_addr_r == ADDR_SOFTRST) && (wr_data_r == SOFTRST_KEY);
   endsequence
   sequence s_kick_write;
      wr_stb_r && (wr_addr_r == ADDR_FAULT) && wr_data_r[KICK_BIT];
   endsequence

   property p_soft_restores;
      s_key_write |=> (ratio_r == RST_RATIO) && (boost1_r == RST_BOOST1)
                      && (boost2_r == RST_BOOST2);
   endproperty
   a_soft_restores: assert property (p_soft_restores)  // [RL14] [RL1] [RL12]
      else $error("soft reset did not restore registers");

   property p_soft_pulse;
      s_key_write |=> o_soft_reset ##1 !o_soft_reset;
   endproperty
   a_soft_pulse: assert property (p_soft_pulse)  // [RL11]
      else $error("soft reset pulse wrong");

   property p_auto_code;
      (o_auto_ratio_select && link.det_valid && !soft_hit)
         |=> (o_ratio_code == $past(link.det_code));
   endproperty
   a_auto_code: assert property (p_auto_code)  // [RL2]
      else $error("detected ratio not stored");

   property p_manual_hold;
      (!o_auto_ratio_select && !wr_stb_r) |=> $stable(o_ratio_code);
   endproperty
   a_manual_hold: assert property (p_manual_hold)  // [RL3]
      else $error("manual ratio changed without a write");

   property p_ratio_write;
      (wr_stb_r && (wr_addr_r == ADDR_RATIO) && !(o_auto_ratio_select && link.det_valid))
         |=> (ratio_r == $past(wr_data_r));
   endproperty
   a_ratio_write: assert property (p_ratio_write)  // [RL4] [RL12]
      else $error("ratio register write lost");

   property p_boost1_write;
      (wr_stb_r && (wr_addr_r == ADDR_BOOST1))
         |=> (o_pullup_driver_speed == $past(wr_data_r[7:6]))
             && (o_discharge_switch_on == $past(wr_data_r[2]))
             && (o_forced_pwm_n == $past(wr_data_r[1]))
             && (o_converter_freq_pick == $past(wr_data_r[0]));
   endproperty
   a_boost1_write: assert property (p_boost1_write)  // [RL5] [RL6] [RL7] [RL8]
      else $error("boost control one fields wrong");

   property p_boost2_write;
      (wr_stb_r && (wr_addr_r == ADDR_BOOST2))
         |=> (o_booster_recovery_mode == $past(wr_data_r[3]))
             && (o_error_amp_gain_pick == $past(wr_data_r[1:0]))
             && (boost2_r == $past(wr_data_r));
   endproperty
   a_boost2_write: assert property (p_boost2_write)  // [RL9] [RL10] [RL12]
      else $error("boost control two fields wrong");

   property p_kick;
      (s_kick_write ##0 o_booster_recovery_mode) |=> o_recovery_attempt ##1 !o_recovery_attempt;
   endproperty
   a_kick: assert property (p_kick)  // [RL13]
      else $error("manual kick gave no single attempt");

   property p_no_stray_attempt;
      o_recovery_attempt |-> $past(wr_stb_r && o_booster_recovery_mode);
   endproperty
   a_no_stray_attempt: assert property (p_no_stray_attempt)  // [RL13]
      else $error("recovery attempt without manual kick");

endmodule : crbc_regs

// *** tb/crbc_host.sv ***
// Host model that drives the two-wire control port
module crbc_host (
   // Clock
   input  wire logic i_ref_clk,
   // Lines
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_low
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle: clock high, data released
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   // Four clocks per phase, twice the port's minimum, leaves slack
   task automatic tick();
      repeat (4) @(posedge i_ref_clk);
      #1;
   endtask : tick
   // Start or repeated start: data falls while clock is high
   task automatic start();
      o_sda_low = 1'b0;
      tick();
      o_scl = 1'b1;
      tick();
      o_sda_low = 1'b1;
      tick();
      o_scl = 1'b0;
      tick();
   endtask : start
   // Stop: data rises while clock is high
   task automatic stop();
      o_sda_low = 1'b1;
      tick();
      o_scl = 1'b1;
      tick();
      o_sda_low = 1'b0;
      tick();
   endtask : stop
   // Nine pulses, MSB first; returns the line level at the end of each high phase, just before the fall
   task automatic byte9(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) begin
         o_sda_low = ~d[i];
         tick();
         o_scl = 1'b1;
         tick();
         q[i] = i_sda;
         o_scl = 1'b0;
         tick();
      end
   endtask : byte9
endmodule : crbc_host

// *** tb/crbc_regs_test.sv ***
// Self-checking bench for the ratio and boost register bank
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin errors++; \
$display("wrong value at %0t: %h vs %h", $time, a, e); end end
module crbc_regs_test import crbc_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [6:0] DEV = 7'h35;  // Not the default, so matching is exercised
   logic       i_ref_clk;
   logic       i_reset;
   logic       i_frame_sync;
   logic       scl;
   logic       host_low;
   wire logic  oe;
   wire logic  sdo;  // Device data value, driven while oe is high
   wire logic  sr;
   wire logic  rec;
   wire logic [12:0] ov;  // All field outputs, packed
   // Pull-up wire: the device value shows only while it drives
   wire logic  sda = (oe ? sdo : 1'b1) & ~host_low;
   logic [7:0] sh [3];  // Expected 0x14..0x16
   logic [8:0] q;
   logic [7:0] rdv;
   int         errors;
   int         samples_checked;
   int         n_sr;
   int         n_rec;
   logic [1:0] wa [5] = '{2'd0, 2'd1, 2'd1, 2'd2, 2'd2};
   logic [7:0] wd [5] = '{8'he9, 8'hf8, 8'h46, 8'hf6, 8'h09};
   crbc_host host (.i_ref_clk(i_ref_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
   crbc_regs #(.DEV_ADDR(DEV)) uut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_scl(scl),
      .i_sda(sda), .o_sda_o(sdo), .o_sda_oe(oe), .i_frame_sync(i_frame_sync),
      .o_auto_ratio_select(ov[12]), .o_ratio_code(ov[11:8]), .o_pullup_driver_speed(ov[7:6]),
      .o_discharge_switch_on(ov[5]), .o_forced_pwm_n(ov[4]), .o_converter_freq_pick(ov[3]),
      .o_booster_recovery_mode(ov[2]), .o_error_amp_gain_pick(ov[1:0]),
      .o_soft_reset(sr), .o_recovery_attempt(rec));
   initial begin
      i_ref_clk = 1'b0;
      forever #2 i_ref_clk = ~i_ref_clk;
   end
   // Count event pulses; each lasts one cycle
   always @(posedge i_ref_clk) begin
      if (sr === 1'b1) n_sr++;
      if (rec === 1'b1) n_rec++;
   end
   task automatic test_done();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done
   task automatic ack(input logic [7:0] b);
      host.byte9({b, 1'b1}, q);
      `CHK(q[0], 1'b0)
   endtask : ack
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.start();
      ack({DEV, 1'b0});
      ack(a);
      ack(d);
      host.stop();
   endtask : wr
   // Pointer write, repeated start, one byte read with a final NACK
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      host.start();
      ack({DEV, 1'b0});
      ack(a);
      host.start();
      ack({DEV, 1'b1});
      host.byte9(9'h1ff, q);
      host.stop();
      `CHK(q[8:1], e)
   endtask : rchk
   task automatic ochk();
      `CHK(ov, {sh[0][4:0], sh[1][7:6], sh[1][2:0], sh[2][3], sh[2][1:0]})
   endtask : ochk
   // One sync pulse; the next pulse closes a period of p clocks
   task automatic fs(input int p);
      i_frame_sync = 1'b1;
      @(posedge i_ref_clk);
      #1;
      i_frame_sync = 1'b0;
      repeat (p - 1) @(posedge i_ref_clk);
      #1;
   endtask : fs
   initial begin
      repeat (40000) @(posedge i_ref_clk);
      errors++;
      test_done();
   end
   initial begin
      i_reset = 1'b1;
      i_frame_sync = 1'b0;
      sh = '{RST_RATIO, RST_BOOST1, RST_BOOST2};
      repeat (2) @(posedge i_ref_clk);
      #1;
      i_reset = 1'b0;
      ochk();
      for (int i = 0; i < 3; i++) rchk(8'(ADDR_RATIO + i), sh[i]);
      rchk(ADDR_SOFTRST, READ_NONE);
      // Every field and reserved bit written and read back
      for (int i = 0; i < 5; i++) begin
         sh[wa[i]] = wd[i];
         wr(8'(ADDR_RATIO + wa[i]), wd[i]);
         rchk(8'(ADDR_RATIO + wa[i]), wd[i]);
         ochk();
      end
      wr(ADDR_FAULT, 8'h08);
      sh[2] = 8'h00;
      wr(ADDR_BOOST2, 8'h00);
      wr(ADDR_FAULT, 8'hff);  // Auto recovery now, so no attempt
      `CHK(n_rec, 1)
      sh[0] = 8'h10;
      wr(ADDR_RATIO, 8'h10);
      for (int i = 0; i <= RATIO_CODES; i++) begin
         fs(i < RATIO_CODES ? int'(RATIO_MULT[i]) : 10);
         if (i > 0) `CHK(ov[11:8], 4'(i - 1))
      end
      rchk(ADDR_RATIO, 8'h19);
      wr(ADDR_RATIO, 8'h05);
      fs(64);
      fs(10);
      `CHK(ov[12:8], 5'h05)
      sh[0] = 8'h05;
      wr(ADDR_SOFTRST, 8'h12);  // Wrong key is dropped
      ochk();
      wr(ADDR_SOFTRST, SOFTRST_KEY);
      sh = '{RST_RATIO, RST_BOOST1, RST_BOOST2};
      ochk();
      `CHK(n_sr, 1)
      rchk(ADDR_BOOST1, RST_BOOST1);
      test_done();
   end
endmodule : crbc_regs_test
